/* File: rtl/ccr_pkg.sv */
// constants and carrier types of the clock, ready and reset generator
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package ccr_pkg;

   localparam logic [1:0] STRAP_CAPTURE_CYCLE  = 2'h3;
   localparam logic [1:0] READY_MIN_CYCLES     = 2'h2;
   localparam logic [1:0] READY_RELEASE_CYCLES = 2'h2;
   localparam int         RESET_MIN_CYCLES     = 16;

   localparam logic       PCLK_RST    = 1'b0;
   localparam logic       SYSCLK_RST  = 1'b0;
   localparam logic       SYSRST_RST  = 1'b1;
   localparam logic [1:0] HIST_RST    = 2'h0;
   localparam logic [1:0] ASYNC_RST   = 2'h3;

   typedef struct packed {
      logic ext_freq;
      logic xtal;
      logic src_sel;
      logic status_zero_n;
      logic status_one_n;
      logic status_driven;
      logic por_n;
      logic sync_ack_n;
      logic sync_sel_n;
      logic async_ack_n;
      logic async_sel_n;
   } pin_bus_t;

   // status and acknowledges idle high, clear asserted
   localparam pin_bus_t PIN_BUS_RST = 11'h0cf;

   typedef enum logic [1:0] {
      RDY_FLOAT,
      RDY_RECOVER,
      RDY_ASSERT
   } ready_state_t;

endpackage : ccr_pkg

/* File: rtl/clock_ready_reset_generator.sv */
// clock, peripheral clock, reset and ready generation
`timescale 1ns/1ps
module clock_ready_reset_generator (
   input  wire logic I_SYS_CLK,
   input  wire logic I_NRST,
   input  wire logic I_XTAL_CLK,
   input  wire logic I_EXT_FREQ_IN,
   input  wire logic I_CLK_SOURCE_SELECT,
   input  wire logic I_STATUS_ZERO_N,
   input  wire logic I_STATUS_ONE_N,
   input  wire logic I_STATUS_DRIVEN,
   input  wire logic I_POWER_ON_CLEAR_N,
   input  wire logic I_SYNC_ACK_N,
   input  wire logic I_SYNC_ACK_SELECT_N,
   input  wire logic I_ASYNC_ACK_N,
   input  wire logic I_ASYNC_ACK_SELECT_N,
   output logic      O_SYSTEM_CLK,
   output logic      O_PERIPHERAL_CLK,
   output logic      O_SYSTEM_RESET,
   output logic      O_READY_N_O,
   output logic      O_READY_N_OE
);

   //----------------------------------------------------------------
   // pin synchronisers
   //----------------------------------------------------------------
   ccr_pkg::pin_bus_t     pins;
   ccr_pkg::pin_bus_t     pin_meta_reg;
   ccr_pkg::pin_bus_t     pin_sync_reg;

   logic                  src_sel_reg;
   logic [1:0]            strap_cnt_reg;
   logic                  sysclk_now;
   logic                  sysclk_reg;
   logic                  fe;
   logic                  st_low;
   logic [1:0]            hist_reg;
   logic                  aligned_reg;
   logic                  force_high;
   logic                  pclk_reg;
   logic                  por_s1_reg;
   logic                  sysrst_reg;
   logic [1:0]            async_s1_reg;
   logic [1:0]            async_s2_reg;
   logic                  async_act;
   logic                  sync_act;
   logic                  take;
   ccr_pkg::ready_state_t rdy_state_reg;
   logic [1:0]            rdy_cnt_reg;

   assign pins = '{ext_freq:      I_EXT_FREQ_IN,
                   xtal:          I_XTAL_CLK,
                   src_sel:       I_CLK_SOURCE_SELECT,
                   status_zero_n: I_STATUS_ZERO_N,
                   status_one_n:  I_STATUS_ONE_N,
                   status_driven: I_STATUS_DRIVEN,
                   por_n:         I_POWER_ON_CLEAR_N,
                   sync_ack_n:    I_SYNC_ACK_N,
                   sync_sel_n:    I_SYNC_ACK_SELECT_N,
                   async_ack_n:   I_ASYNC_ACK_N,
                   async_sel_n:   I_ASYNC_ACK_SELECT_N};

   always_ff @(posedge I_SYS_CLK or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         pin_meta_reg <= ccr_pkg::PIN_BUS_RST;
         pin_sync_reg <= ccr_pkg::PIN_BUS_RST;
      end
      else
      begin
         pin_meta_reg <= pins;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   //----------------------------------------------------------------
   // system clock source and falling-edge enable
   //----------------------------------------------------------------
   // strap caught once synchronised values are valid after release
   always_ff @(posedge I_SYS_CLK or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         strap_cnt_reg <= 2'h0;
         src_sel_reg   <= 1'b0;
      end
      else if (strap_cnt_reg != ccr_pkg::STRAP_CAPTURE_CYCLE)
      begin
         strap_cnt_reg <= strap_cnt_reg + 2'h1;
         src_sel_reg   <= pin_sync_reg.src_sel;
      end
   end

   assign sysclk_now = src_sel_reg ? pin_sync_reg.ext_freq
                                   : pin_sync_reg.xtal;

   always_ff @(posedge I_SYS_CLK or negedge I_NRST)
   begin
      if (!I_NRST)
         sysclk_reg <= ccr_pkg::SYSCLK_RST;
      else
         sysclk_reg <= sysclk_now;
   end

   // every "falling edge" below is this one-cycle enable
   assign fe = sysclk_reg & ~sysclk_now;

   //----------------------------------------------------------------
   // peripheral clock
   //----------------------------------------------------------------
   assign st_low = pin_sync_reg.status_driven &
                   (~pin_sync_reg.status_zero_n | ~pin_sync_reg.status_one_n);

   always_ff @(posedge I_SYS_CLK or negedge I_NRST)
   begin
      if (!I_NRST)
         hist_reg <= ccr_pkg::HIST_RST;
      else if (fe)
         hist_reg <= {hist_reg[0], st_low};
   end

   // after alignment the phase is fixed; forcing again could only slip it
   always_ff @(posedge I_SYS_CLK or negedge I_NRST)
   begin
      if (!I_NRST)
         aligned_reg <= 1'b0;
      else if (sysrst_reg)
         aligned_reg <= 1'b0;
      else if (fe && !st_low && hist_reg[0])
         aligned_reg <= 1'b1;
   end

   assign force_high = (&hist_reg) & ~aligned_reg;

   always_ff @(posedge I_SYS_CLK or negedge I_NRST)
   begin
      if (!I_NRST)
         pclk_reg <= ccr_pkg::PCLK_RST;
      else if (fe)
      begin
         if (force_high)
            pclk_reg <= 1'b1;
         else
            pclk_reg <= ~pclk_reg;
      end
   end

   //----------------------------------------------------------------
   // system reset
   //----------------------------------------------------------------
   always_ff @(posedge I_SYS_CLK or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         por_s1_reg <= 1'b0;
         sysrst_reg <= ccr_pkg::SYSRST_RST;
      end
      else if (fe)
      begin
         por_s1_reg <= pin_sync_reg.por_n;
         sysrst_reg <= ~por_s1_reg;
      end
   end

   //----------------------------------------------------------------
   // acknowledge sampling
   //----------------------------------------------------------------
   always_ff @(posedge I_SYS_CLK or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         async_s1_reg <= ccr_pkg::ASYNC_RST;
         async_s2_reg <= ccr_pkg::ASYNC_RST;
      end
      else if (fe)
      begin
         async_s1_reg <= {pin_sync_reg.async_ack_n,
                          pin_sync_reg.async_sel_n};
         async_s2_reg <= async_s1_reg;
      end
   end

   assign async_act = (async_s2_reg == 2'h0);
   assign sync_act  = ~pin_sync_reg.sync_ack_n & ~pin_sync_reg.sync_sel_n;
   // async source wins; sync pair is not even looked at then
   assign take      = async_act ? 1'b1 : sync_act;

   //----------------------------------------------------------------
   // ready generator
   //----------------------------------------------------------------
   always_ff @(posedge I_SYS_CLK or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         rdy_state_reg <= ccr_pkg::RDY_ASSERT;
         rdy_cnt_reg   <= 2'h0;
      end
      else if (fe)
      begin
         if (sysrst_reg)
         begin
            rdy_state_reg <= ccr_pkg::RDY_ASSERT;
            rdy_cnt_reg   <= 2'h0;
         end
         else if (st_low)
         begin
            rdy_state_reg <= ccr_pkg::RDY_RECOVER;
            rdy_cnt_reg   <= ccr_pkg::READY_RELEASE_CYCLES - 2'h1;
         end
         else
         begin
            case (rdy_state_reg)
               ccr_pkg::RDY_RECOVER:
               begin
                  // pull-up needs this time; asserting now would glitch
                  if (rdy_cnt_reg != 2'h0)
                     rdy_cnt_reg <= rdy_cnt_reg - 2'h1;
                  else
                     rdy_state_reg <= ccr_pkg::RDY_FLOAT;
               end
               ccr_pkg::RDY_FLOAT:
               begin
                  if (pclk_reg && take)
                  begin
                     rdy_state_reg <= ccr_pkg::RDY_ASSERT;
                     rdy_cnt_reg   <= ccr_pkg::READY_MIN_CYCLES - 2'h1;
                  end
               end
               ccr_pkg::RDY_ASSERT:
               begin
                  if (rdy_cnt_reg != 2'h0)
                     rdy_cnt_reg <= rdy_cnt_reg - 2'h1;
                  else if (pclk_reg && !take)
                     rdy_state_reg <= ccr_pkg::RDY_FLOAT;
               end
               default:
               begin
                  rdy_state_reg <= ccr_pkg::RDY_FLOAT;
                  rdy_cnt_reg   <= 2'h0;
               end
            endcase
         end
      end
   end

   //----------------------------------------------------------------
   // outputs
   //----------------------------------------------------------------
   assign O_SYSTEM_CLK     = sysclk_reg;
   assign O_PERIPHERAL_CLK = pclk_reg;
   assign O_SYSTEM_RESET   = sysrst_reg;
   // open drain: only ever pulls low
   assign O_READY_N_O      = 1'b0;
   assign O_READY_N_OE     = (rdy_state_reg == ccr_pkg::RDY_ASSERT);

   //----------------------------------------------------------------
   // assertions
   //----------------------------------------------------------------
   default clocking cb @(posedge I_SYS_CLK);
   endclocking
   default disable iff (!I_NRST);

   sequence s_fe_status_low;
      fe && st_low && !sysrst_reg;
   endsequence

   sequence s_fe_reset;
      fe && sysrst_reg;
   endsequence

   sequence s_fe_take;
      fe && !sysrst_reg && !st_low && pclk_reg && take
         && rdy_state_reg == ccr_pkg::RDY_FLOAT;
   endsequence

   a_clk_source_mux: assert property (
      O_SYSTEM_CLK == $past(src_sel_reg ? pin_sync_reg.ext_freq
                                        : pin_sync_reg.xtal))
      else $error("system clock not from selected source");

   a_pclk_divide: assert property (
      fe && !force_high |=> O_PERIPHERAL_CLK != $past(O_PERIPHERAL_CLK))
      else $error("peripheral clock did not toggle");

   a_pclk_forced_high: assert property (
      fe && force_high |=> O_PERIPHERAL_CLK)
      else $error("peripheral clock not held high");

   a_pclk_only_stretch: assert property (
      $fell(O_PERIPHERAL_CLK) |-> $past(fe) && !$past(force_high))
      else $error("peripheral clock low phase altered");

   a_pclk_still: assert property (
      !fe |=> $stable(O_PERIPHERAL_CLK))
      else $error("peripheral clock moved off the falling edge");

   a_reset_follows: assert property (
      fe && !por_s1_reg |=> O_SYSTEM_RESET)
      else $error("reset output not raised");

   a_reset_release: assert property (
      fe && por_s1_reg |=> !O_SYSTEM_RESET)
      else $error("reset output not released");

   a_ready_float: assert property (
      s_fe_status_low |=> !O_READY_N_OE ##1 !O_READY_N_OE)
      else $error("ready not released on status");

   a_ready_reset: assert property (
      s_fe_reset |=> O_READY_N_OE)
      else $error("ready not forced during reset");

   a_ready_take: assert property (
      s_fe_take |=> O_READY_N_OE && rdy_cnt_reg == 2'h1)
      else $error("ready not asserted on acknowledge");

   a_ready_min_hold: assert property (
      $fell(O_READY_N_OE) |-> $past(st_low) || $past(rdy_cnt_reg) == 2'h0)
      else $error("ready released too early");

   a_ready_recover: assert property (
      fe && !sysrst_reg && !st_low && rdy_state_reg == ccr_pkg::RDY_RECOVER
         && pclk_reg && take
         |=> !O_READY_N_OE)
      else $error("ready driven during pull-up time");

   a_sync_gate: assert property (
      $rose(O_READY_N_OE) && !$past(sysrst_reg)
         |-> $past(pclk_reg) && !$past(st_low))
      else $error("acknowledge taken outside sampling window");

   // falling edges since the last status-low edge, saturating; checker helper only
   logic [1:0] fe_since_low_reg;

   always_ff @(posedge I_SYS_CLK or negedge I_NRST)
   begin
      if (!I_NRST)
         fe_since_low_reg <= ccr_pkg::READY_RELEASE_CYCLES;
      else if (fe && st_low && !sysrst_reg)
         fe_since_low_reg <= 2'h0;
      else if (fe && fe_since_low_reg != ccr_pkg::READY_RELEASE_CYCLES)
         fe_since_low_reg <= fe_since_low_reg + 2'h1;
   end

   a_ready_release_span: assert property (
      fe_since_low_reg < ccr_pkg::READY_RELEASE_CYCLES && !sysrst_reg
         |-> !O_READY_N_OE)
      else $error("ready driven inside pull-up span");

   a_strap_held: assert property (
      strap_cnt_reg == ccr_pkg::STRAP_CAPTURE_CYCLE |=> $stable(src_sel_reg))
      else $error("clock source changed after capture");

endmodule : clock_ready_reset_generator

/* File: testbench/bus_partner.sv */
// partner model: clock sources, bus status, acknowledges and clear
`timescale 1ns/1ps
module bus_partner (
   input  wire logic         i_clk,
   input  wire logic         i_sys_clk_out,
   output ccr_pkg::pin_bus_t o_pins
);
   int xtal_cnt = 0;
   int ext_cnt  = 0;

   initial o_pins = ccr_pkg::PIN_BUS_RST;

   // free-running slow sources, unequal rates so the strap choice shows
   always @(posedge i_clk)
   begin
      xtal_cnt <= (xtal_cnt + 1) % 4;
      ext_cnt  <= (ext_cnt + 1) % 6;
      if (xtal_cnt == 3)
         o_pins.xtal <= #2 ~o_pins.xtal;
      if (ext_cnt == 5)
         o_pins.ext_freq <= #2 ~o_pins.ext_freq;
   end

   // bus pins move just after a system clock fall, away from its sampling
   task automatic step(input int n);
      repeat (n) @(negedge i_sys_clk_out);
      @(posedge i_clk);
      #2;
   endtask : step

   task automatic strap(input logic src);
      o_pins.src_sel = src;
   endtask : strap

   task automatic por(input logic v);
      o_pins.por_n = v;
   endtask : por

   // driven low means the pins float and the pull-ups win
   task automatic status(input logic z, input logic o, input logic driven);
      o_pins.status_zero_n = z;
      o_pins.status_one_n  = o;
      o_pins.status_driven = driven;
   endtask : status

   // one source selected per bus cycle
   task automatic ack(input bit use_async, input logic a, input logic s);
      if (use_async)
         {o_pins.async_ack_n, o_pins.async_sel_n} = {a, s};
      else
         {o_pins.sync_ack_n, o_pins.sync_sel_n} = {a, s};
   endtask : ack
endmodule : bus_partner

/* File: testbench/tb.sv */
// self-checking bench of the clock, ready and reset generator
`timescale 1ns/1ps
module tb;
   logic              sys_clk     = 1'b0;
   logic              nrst        = 1'b0;
   ccr_pkg::pin_bus_t pins;
   logic              sclk;
   logic              pclk;
   logic              sys_rst;
   logic              rdy_oe;
   logic              rdy_o;
   int                n_fail      = 0;
   int                comparisons = 0;
   int                hi_run      = 0;
   int                lo_run      = 0;
   int                hi_last     = 0;
   int                lo_last     = 0;
   int                hi_max      = 0;
   always #10 sys_clk = ~sys_clk;
   bus_partner bp (
      .i_clk         (sys_clk),
      .i_sys_clk_out (sclk),
      .o_pins        (pins)
   );
   clock_ready_reset_generator uut (
      .I_SYS_CLK            (sys_clk),
      .I_NRST               (nrst),
      .I_XTAL_CLK           (pins.xtal),
      .I_EXT_FREQ_IN        (pins.ext_freq),
      .I_CLK_SOURCE_SELECT  (pins.src_sel),
      .I_STATUS_ZERO_N      (pins.status_zero_n),
      .I_STATUS_ONE_N       (pins.status_one_n),
      .I_STATUS_DRIVEN      (pins.status_driven),
      .I_POWER_ON_CLEAR_N   (pins.por_n),
      .I_SYNC_ACK_N         (pins.sync_ack_n),
      .I_SYNC_ACK_SELECT_N  (pins.sync_sel_n),
      .I_ASYNC_ACK_N        (pins.async_ack_n),
      .I_ASYNC_ACK_SELECT_N (pins.async_sel_n),
      .O_SYSTEM_CLK         (sclk),
      .O_PERIPHERAL_CLK     (pclk),
      .O_SYSTEM_RESET       (sys_rst),
      .O_READY_N_O          (rdy_o),
      .O_READY_N_OE         (rdy_oe)
   );
   // peripheral clock run lengths, read once the edge has settled
   always @(posedge sys_clk)
   begin
      #1;
      if (pclk === 1'b1 && lo_run > 0)
         lo_last = lo_run;
      if (pclk !== 1'b1 && hi_run > 0)
         hi_last = hi_run;
      hi_run = (pclk === 1'b1) ? hi_run + 1 : 0;
      lo_run = (pclk === 1'b1) ? 0 : lo_run + 1;
      hi_max = (hi_run > hi_max) ? hi_run : hi_max;
   end
   task automatic tick;
      @(posedge sys_clk);
      #2;
   endtask : tick
   task automatic chk(input logic got, input string what);
      comparisons++;
      if (got !== 1'b1)
      begin
         n_fail++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask : chk
   // bounded wait on reset out (0) or ready drive (1)
   task automatic await(input bit which, input logic v, input int lim, output int n);
      for (n = 0; (which ? rdy_oe : sys_rst) !== v && n < lim; n++)
         tick();
   endtask : await
   task automatic end_sim;
      if (n_fail == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   task automatic t_clear;
      int n;
      bp.por(1'b0);
      await(1'b0, 1'b1, 24, n);
      chk(sys_rst === 1'b1, "reset out not raised");
      await(1'b1, 1'b1, 12, n);
      chk(rdy_oe === 1'b1, "ready not forced");
      bp.step(20);
      bp.por(1'b1);
      await(1'b0, 1'b0, 30, n);
      chk(sys_rst === 1'b0, "reset out stuck");
   endtask : t_clear
   task automatic t_power_up(input logic src);
      nrst = 1'b0;
      tick();
      bp.strap(src);
      repeat (11) tick();
      nrst = 1'b1;
      t_clear();
      bp.step(4);
      chk(hi_last == (src ? 12 : 8) && lo_last == hi_last, "pclk rate");
   endtask : t_power_up
   // first bus cycle stretches, later ones must not
   task automatic t_align;
      for (int i = 0; i < 2; i++)
      begin
         hi_max = 0;
         bp.status(1'b0, 1'b0, 1'b1);
         bp.step(4);
         bp.status(1'b1, 1'b1, 1'b1);
         bp.step(3);
         chk((i == 0) ? (hi_max > 8 && lo_last == 8) : (hi_max == 8), "pclk phase");
      end
   endtask : t_align
   task automatic t_ready(input bit async_src);
      int n;
      bp.status(1'b0, 1'b0, 1'b1);
      bp.step(1);
      bp.status(1'b1, 1'b1, 1'b1);
      bp.ack(async_src, 1'b0, 1'b0);
      await(1'b1, 1'b1, 64, n);
      chk(rdy_oe === 1'b1 && rdy_o === 1'b0 && n >= 14, "ready assert");
      bp.ack(async_src, 1'b1, 1'b1);
      await(1'b1, 1'b0, 64, n);
      chk(rdy_oe === 1'b0 && n >= 16, "ready hold");
   endtask : t_ready
   // a lone acknowledge or a lone select must not end the cycle
   task automatic t_half_pair;
      int n;
      bp.status(1'b1, 1'b0, 1'b1);
      bp.step(1);
      bp.status(1'b1, 1'b1, 1'b1);
      bp.ack(1'b0, 1'b0, 1'b1);
      bp.ack(1'b1, 1'b1, 1'b0);
      await(1'b1, 1'b1, 40, n);
      chk(rdy_oe === 1'b0, "ack without select");
      bp.ack(1'b0, 1'b1, 1'b0);
      bp.ack(1'b1, 1'b0, 1'b1);
      await(1'b1, 1'b1, 40, n);
      chk(rdy_oe === 1'b0, "select without ack");
      bp.ack(1'b1, 1'b1, 1'b1);
      bp.ack(1'b0, 1'b0, 1'b0);
      await(1'b1, 1'b1, 40, n);
      chk(rdy_oe === 1'b1 && rdy_o === 1'b0, "full pair not taken");
      bp.ack(1'b0, 1'b1, 1'b1);
      await(1'b1, 1'b0, 40, n);
      chk(rdy_oe === 1'b0, "ready not dropped");
   endtask : t_half_pair
   task automatic t_undriven;
      int n;
      bp.status(1'b0, 1'b0, 1'b0);
      bp.ack(1'b0, 1'b0, 1'b0);
      await(1'b1, 1'b1, 40, n);
      chk(rdy_oe === 1'b1, "floating status");
      bp.status(1'b0, 1'b1, 1'b1);
      await(1'b1, 1'b0, 14, n);
      chk(rdy_oe === 1'b0, "ready kept");
      bp.ack(1'b0, 1'b1, 1'b1);
      bp.status(1'b1, 1'b1, 1'b1);
   endtask : t_undriven
   initial
   begin
      t_power_up(1'b1);
      t_power_up(1'b0);
      t_align();
      t_ready(1'b0);
      t_ready(1'b1);
      t_half_pair();
      t_undriven();
      t_clear();
      end_sim();
   end
   // sequence needs about 1100 cycles; allow 10000
   initial
   begin
      #200000;
      n_fail++;
      end_sim();
   end
endmodule : tb
